/* dci_control_inputs.sv */
// Control-input logic: unit select gating, write gate, head select and stepping.
//
// Contract
// - Exactly one unit-select line, the drive's own, qualifies shared inputs.
// - Shared inputs are ignored unless own unit-select is active.
// - Reduced current plus write gate writes with the lower current.
// - Low write gate enables recording on the addressed head.
// - High write gate selects read mode, data flows to host.
// - Head address decoded binary 0..3, first line least significant.
// - Both head lines high selects head zero.
// - Direction high or open steps heads outward.
// - Direction low steps heads inward.
// - Head motion starts on the rising trailing edge of step.
// - Each accepted step moves heads exactly one track, unless it would pass track zero or the last cylinder.
// - Unit-select active low connects the interface to shared lines.
module dci_control_inputs
  import dci_pkg::*;
#(
  parameter int unsigned CYL_W   = DCI_CYL_W,
  parameter logic [8:0]  CYL_MAX = DCI_CYL_MAX
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic [1:0]       i_unit_num,
  input  wire logic [3:0]       i_unit_sel_n,
  input  wire dci_ctrl_t        i_ctrl,
  output logic                  o_selected,
  output logic                  o_write_en,
  output logic                  o_read_mode,
  output logic                  o_low_current,
  output logic [1:0]            o_head,
  output logic                  o_step_pulse,
  output logic                  o_step_inward,
  output logic [CYL_W-1:0]      o_cylinder,
  output logic                  o_track_zero
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Three stages per pin; a change counts only once stages two and three agree,
  // which trades two cycles of latency for immunity to a single glitch.
  localparam int unsigned NIN = 10;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] clean_reg;

  assign pins = {i_unit_sel_n, i_ctrl};

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg    <= {NIN{1'h1}};
      s2_reg    <= {NIN{1'h1}};
      s3_reg    <= {NIN{1'h1}};
      clean_reg <= {NIN{1'h1}};
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NIN; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          clean_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  dci_ctrl_t  ctrl;
  logic [3:0] usel_n;

  assign ctrl   = clean_reg[5:0];
  assign usel_n = clean_reg[9:6];

  // The unit number is a strap; it is caught by a clocked process after reset.
  // It is not filtered, so it must stay fixed while the drive is in use.
  logic [1:0] unit_reg;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_reg <= DCI_UNIT_RST;
    end else begin
      unit_reg <= i_unit_num;
    end
  end

  // ************************************************************
  // Unit selection
  // ************************************************************
  logic sel;

  assign sel = ~usel_n[unit_reg];

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_selected <= 1'h0;
    end else begin
      o_selected <= sel;
    end
  end

  // ************************************************************
  // Write gate, current and head select
  // ************************************************************
  dci_rw_t rw_next;
  dci_rw_t rw_reg;

  always_comb begin
    rw_next = DCI_RW_RST;
    if (sel) begin
      rw_next.write_en    = ~ctrl.wgate_n;
      rw_next.low_current = ~ctrl.wgate_n & ~ctrl.rwc_n;
      rw_next.head        = {~ctrl.hsel1_n, ~ctrl.hsel0_n};
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rw_reg <= DCI_RW_RST;
    end else begin
      rw_reg <= rw_next;
    end
  end

  assign o_write_en    = rw_reg.write_en;
  assign o_low_current = rw_reg.low_current;
  assign o_head        = rw_reg.head;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_read_mode <= 1'h1;
    end else begin
      o_read_mode <= ~rw_next.write_en;
    end
  end

  // ************************************************************
  // Stepping
  // ************************************************************
  // Direction is taken when the pulse returns high; the host keeps it steady then,
  // so sampling at the trailing edge is safe.
  logic step_act_reg;
  logic step_rise;
  logic inward;

  assign inward = ~ctrl.dir_n;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_act_reg <= 1'h0;
    end else begin
      step_act_reg <= sel & ~ctrl.step_n;
    end
  end

  assign step_rise = step_act_reg & ctrl.step_n & sel;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_step_pulse  <= 1'h0;
      o_step_inward <= 1'h0;
    end else begin
      o_step_pulse <= step_rise;
      if (step_rise) begin
        o_step_inward <= inward;
      end
    end
  end

  // ************************************************************
  // Track position
  // ************************************************************
  // The counter saturates at both ends; a mechanical stop would hold the
  // carriage there anyway, so counting past it would only lose the position.
  logic [CYL_W-1:0] cyl_reg;
  logic [CYL_W-1:0] cyl_next;

  always_comb begin
    cyl_next = cyl_reg;
    if (step_rise) begin
      if (inward && cyl_reg != CYL_W'(CYL_MAX)) begin
        cyl_next = cyl_reg + CYL_W'(1);
      end else if (!inward && cyl_reg != '0) begin
        cyl_next = cyl_reg - CYL_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyl_reg      <= CYL_W'(DCI_CYL_RST);
      o_track_zero <= 1'h1;
    end else begin
      cyl_reg      <= cyl_next;
      o_track_zero <= (cyl_next == '0);
    end
  end

  assign o_cylinder = cyl_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_unsel_no_write: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !$past(sel) |-> !o_write_en) else $error("Write enabled while not selected.");

  a_low_cur_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_low_current |-> o_write_en) else $error("Low current without write gate.");

  a_read_write_excl: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_read_mode == !o_write_en) else $error("Read mode and write enable disagree.");

  a_head_decode: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(sel) |-> o_head == {~$past(ctrl.hsel1_n), ~$past(ctrl.hsel0_n)}) else $error("Head decode wrong.");

  a_step_trailing: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    sel && ctrl.step_n && $past(sel && !ctrl.step_n) |=> o_step_pulse) else $error("Missed trailing edge.");

  a_step_no_lead: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $fell(ctrl.step_n) |=> !o_step_pulse) else $error("Step taken on leading edge.");

  a_step_inward: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    step_rise && inward && cyl_reg != CYL_W'(CYL_MAX) |=> cyl_reg == $past(cyl_reg) + CYL_W'(1))
    else $error("Inward step did not add one track.");

  a_step_outward: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    step_rise && !inward && cyl_reg != '0 |=> cyl_reg == $past(cyl_reg) - CYL_W'(1))
    else $error("Outward step did not remove one track.");

  a_floor_zero: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    cyl_reg == '0 && !(step_rise && inward) |=> cyl_reg == '0) else $error("Counter left zero outward.");

  a_no_step_idle: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !step_rise |=> cyl_reg == $past(cyl_reg)) else $error("Track moved without a step.");

  a_write_gate_low: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(sel && !ctrl.wgate_n) |-> o_write_en && !o_read_mode)
    else $error("Active write gate did not enable recording.");

  a_read_gate_high: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(ctrl.wgate_n) |-> o_read_mode && !o_write_en)
    else $error("Inactive write gate did not give read mode.");

  a_low_cur_set: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(sel && !ctrl.wgate_n && !ctrl.rwc_n) |-> o_low_current)
    else $error("Lower write current not applied.");

  a_head_idle_zero: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    $past(ctrl.hsel0_n && ctrl.hsel1_n) |-> o_head == 2'h0)
    else $error("Idle head lines did not pick head zero.");

  a_unsel_no_step: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !$past(sel) |-> !o_step_pulse)
    else $error("Step taken while not selected.");

  a_unsel_head_zero: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !$past(sel) |-> o_head == 2'h0 && !o_low_current)
    else $error("Shared lines used while not selected.");

  a_dir_captured: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_step_pulse |-> o_step_inward == $past(!ctrl.dir_n))
    else $error("Step direction not taken from the direction line.");

  a_own_select: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_selected == !$past(usel_n[unit_reg]))
    else $error("Selected flag does not follow own select line.");

  a_track_zero_flag: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_track_zero == (o_cylinder == '0))
    else $error("Track zero flag disagrees with the counter.");

  a_cyl_ceiling: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    o_cylinder <= CYL_W'(CYL_MAX))
    else $error("Track counter beyond the last cylinder.");

endmodule // dci_control_inputs

/* dci_control_inputs_tb.sv */
// Self-checking testbench for the drive control-input logic.
module dci_control_inputs_tb
  import dci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic       i_ref_clk = 1'b0;
  logic       i_rst_n   = 1'b0;
  logic [1:0] i_unit_num = 2'h1;
  logic [3:0] sel_n;
  dci_ctrl_t  ctrl;
  logic       o_selected, o_write_en, o_read_mode, o_low_current;
  logic       o_step_pulse, o_step_inward, o_track_zero;
  logic [1:0] o_head;
  logic [8:0] o_cylinder;
  int         err_total = 0;
  int         checked   = 0;
  int         pulses    = 0;
  int         exp_cyl   = 0;
  integer     seed      = 32'h1925;
  logic [31:0] r;
  logic [4:0]  lv;

  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_step_pulse === 1'b1) pulses <= pulses + 1;

  dci_host_model i_dci_host_model (.i_clk(i_ref_clk), .o_unit_sel_n(sel_n), .o_ctrl(ctrl));

  dci_control_inputs i_dci_control_inputs (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_unit_num(i_unit_num),
    .i_unit_sel_n(sel_n), .i_ctrl(ctrl), .o_selected(o_selected),
    .o_write_en(o_write_en), .o_read_mode(o_read_mode), .o_low_current(o_low_current),
    .o_head(o_head), .o_step_pulse(o_step_pulse), .o_step_inward(o_step_inward),
    .o_cylinder(o_cylinder), .o_track_zero(o_track_zero));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Unit 1 is this drive; the other fields only count while it is selected.
  function automatic logic [4:0] exp_lv(input logic [3:0] s, input dci_ctrl_t c);
    logic sel;
    logic we;
    sel = ~s[1];
    we  = sel & ~c.wgate_n;
    return {sel, we, we & ~c.rwc_n, sel ? {~c.hsel1_n, ~c.hsel0_n} : 2'h0};
  endfunction

  task automatic run_step(input logic [2:0] u, input logic inw);
    logic acc;
    int   p0;
    acc = (u == 3'h1);
    i_dci_host_model.pick(u);
    repeat (6) @(negedge i_ref_clk);
    p0 = pulses;
    i_dci_host_model.step(inw);
    repeat (4) @(negedge i_ref_clk);
    if (acc) exp_cyl = inw ? ((exp_cyl < DCI_CYL_MAX) ? exp_cyl + 1 : exp_cyl) : ((exp_cyl > 0) ? exp_cyl - 1 : 0);
    chk(9'(pulses - p0), {8'h00, acc});
    chk(o_cylinder, 9'(exp_cyl));
    chk({8'h00, o_track_zero}, {8'h00, exp_cyl == 0});
    if (acc) chk({8'h00, o_step_inward}, {8'h00, inw});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (8) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    chk(o_cylinder, DCI_CYL_RST);
    chk({7'h00, o_track_zero, o_read_mode}, 9'h003);
    $display("reset test done");
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      i_dci_host_model.pick(3'(r[31:8] % 5));
      i_dci_host_model.setup(r[0], r[2:1], 9'((r[7:3] * 5) % 153));
      repeat (8) @(negedge i_ref_clk);
      lv = exp_lv(sel_n, ctrl);
      chk({4'h0, o_selected, o_write_en, o_low_current, o_head}, {4'h0, lv});
      chk({8'h00, o_read_mode}, {8'h00, ~lv[3]});
    end
    $display("level test done");
    i_dci_host_model.setup(1'b0, 2'h0, 9'h000);
    run_step(3'h1, 1'b0);
    for (int k = 0; k < 156; k++) run_step(3'h1, 1'b1);
    $display("saturation test done");
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    exp_cyl = 0;
    chk(o_cylinder, DCI_CYL_RST);
    chk({7'h00, o_track_zero, o_read_mode}, 9'h003);
    $display("mid-run reset test done");
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      run_step(3'(r[31:8] % 5), r[0]);
    end
    $display("random step test done");
    complete_run;
  end

  initial begin
    repeat (30000) @(negedge i_ref_clk);
    err_total++;
    complete_run;
  end
endmodule // dci_control_inputs_tb

/* dci_host_model.sv */
// Host controller model driving the shared and select lines of the drive.
module dci_host_model
  import dci_pkg::*;
(
  input  wire logic  i_clk,
  output logic [3:0] o_unit_sel_n,
  output dci_ctrl_t  o_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines are pulled up, so released lines read high.
  initial begin
    o_unit_sel_n = 4'hF;
    o_ctrl       = DCI_CTRL_IDLE;
  end

  task automatic pick(input logic [2:0] u);
    @(negedge i_clk);
    o_unit_sel_n = (u < 3'h4) ? ~(4'h1 << u) : 4'hF;
  endtask

  task automatic setup(input logic wr, input logic [1:0] hd, input logic [8:0] cyl);
    @(negedge i_clk);
    o_ctrl.wgate_n = ~wr;
    o_ctrl.hsel0_n = ~hd[0];
    o_ctrl.hsel1_n = ~hd[1];
    o_ctrl.rwc_n   = ~(wr && cyl >= 9'h080);
  endtask

  task automatic step(input logic inward);
    @(negedge i_clk);
    o_ctrl.dir_n = ~inward;
    @(negedge i_clk);
    o_ctrl.step_n = 1'b0;
    repeat (6) @(negedge i_clk);
    o_ctrl.step_n = 1'b1;
    repeat (6) @(negedge i_clk);
  endtask
endmodule // dci_host_model

/* dci_pkg.sv */
// Package of constants and carrier types for the drive control-input logic.
package dci_pkg;

  // ************************************************************
  // Sizes and reset values
  // ************************************************************
  localparam int unsigned DCI_NUM_UNITS  = 4;
  localparam int unsigned DCI_SYNC_DEPTH = 3;
  localparam int unsigned DCI_CYL_W      = 9;
  localparam logic [8:0]  DCI_CYL_RST    = 9'h000;
  localparam logic [8:0]  DCI_CYL_MAX    = 9'h098;
  localparam logic [1:0]  DCI_HEAD_RST   = 2'h0;
  localparam logic [1:0]  DCI_UNIT_RST   = 2'h0;

  // ************************************************************
  // Control inputs, grouped as they arrive at the connector
  // ************************************************************
  typedef struct packed {
    logic rwc_n;
    logic wgate_n;
    logic hsel0_n;
    logic hsel1_n;
    logic step_n;
    logic dir_n;
  } dci_ctrl_t;

  localparam dci_ctrl_t DCI_CTRL_IDLE = 6'h3F;

  // ************************************************************
  // Write channel state delivered to the read/write circuits
  // ************************************************************
  typedef struct packed {
    logic       write_en;
    logic       low_current;
    logic [1:0] head;
  } dci_rw_t;

  localparam dci_rw_t DCI_RW_RST = 4'h0;

endpackage : dci_pkg
